/* File: hw/sms_selector.sv */
/*
 * sms_selector: safety operating-state selector for the reduced motion
 * mode, with sixteen motion-mode variants, transitions and activation
 * timer.
 * assumes: all inputs synchronous to CLOCK; variant configuration static
 * while selected; transition lengths given in clock cycles.
 */
// Functional notes
// - sixteen variants, each selectable and configurable
// - speed limit always, optional checks per variant
// - select needs selector, enabling, variant input
// - emergency stop beats motion selection
// - deceleration transition precedes variant entry
// - after transition speed limit plus configured checks
// - enabling held past limit flags overrun
// - timer runs only with full selection
// - zero limit disables activation supervision
// - direct variant change keeps timer running
// - diagnostic reports active variant 1 to 16
// - selection request indication readable
// - status shows variant active
// - transition keeps old diagnostic, supervision, flag
// - stop transitions keep old diagnostic, supervision
// - new supervision only after transition ends
// - standstill needs no estop, no motion selection
`timescale 1ns/10ps
module sms_selector
    import sms_pkg::*;
#(
    parameter int NUM_VARIANTS = SMS_NUM_VARIANTS,
    parameter int TICK_CYC = SMS_TICK_CYC
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // operator safety inputs
    input wire logic MODE_SELECTOR_INPUT,
    input wire logic ENABLING_CONTROL_INPUT,
    input wire logic [NUM_VARIANTS-1:0] VARIANT_SELECT_INPUT,
    input wire logic EMERGENCY_STOP_INPUT,
    // configuration
    input wire sms_cfg_t [NUM_VARIANTS-1:0] VARIANT_CFG,
    input wire logic STANDSTILL_USES_CAT_TWO,
    input wire logic [SMS_TRANS_W-1:0] DECEL_TRANS_CYC,
    input wire logic [SMS_TRANS_W-1:0] STOP_TRANS_CYC,
    // status
    output logic [4:0] VARIANT_ACTIVE_DIAGNOSTIC,
    output logic MOTION_REQUEST_PRESENT,
    output logic MOTION_MODE_ACTIVE,
    output logic TRANSITION_IN_PROGRESS,
    output logic ACTIVATION_OVERRUN_ERROR,
    output sms_sup_t SUPERVISION
);
    ////////////////////////////////////////////////////////////////////
    // sampled inputs
    logic ms_r;                          // mode selector
    logic ec_r;                          // enabling control
    logic estop_r;                       // emergency stop request
    logic [NUM_VARIANTS-1:0] vsel_r;     // variant selects

    // inputs taken on the clock
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ms_r <= 1'b0;
            ec_r <= 1'b0;
            estop_r <= 1'b0;
            vsel_r <= '0;
        end else begin
            ms_r <= MODE_SELECTOR_INPUT;
            ec_r <= ENABLING_CONTROL_INPUT;
            estop_r <= EMERGENCY_STOP_INPUT;
            vsel_r <= VARIANT_SELECT_INPUT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // variant decode
    logic [SMS_IDX_W-1:0] req_idx;       // lowest asserted variant
    logic any_vsel;                      // some variant select present

    // priority encode; far side keeps only one asserted
    always_comb begin
        req_idx = '0;
        for (int i = NUM_VARIANTS - 1; i >= 0; i--) begin
            if (vsel_r[i]) begin
                req_idx = SMS_IDX_W'(i);
            end
        end
    end

    assign any_vsel = |vsel_r;
    // complete motion selection on the three inputs
    wire full_sel = ms_r && ec_r && any_vsel;
    // selection valid only if variant configured selectable
    wire sel_ok = full_sel && VARIANT_CFG[req_idx].selectable;
    // motion request only without emergency stop
    wire motion_req = sel_ok && !estop_r;
    // standstill request yields to estop and motion selection
    wire stand_req = ms_r && !estop_r && !full_sel;
    // activation timer runs on the full selection
    wire timer_run = full_sel;

    ////////////////////////////////////////////////////////////////////
    // state registers
    sms_state_t state_r, state_nxt;       // operating state
    logic [SMS_IDX_W-1:0] act_idx_r;      // variant in force
    logic [SMS_IDX_W-1:0] act_idx_nxt;
    logic [SMS_IDX_W-1:0] tgt_idx_r;      // variant being entered
    logic [SMS_IDX_W-1:0] tgt_idx_nxt;
    logic trans_start;                    // pulse to transition timer
    logic [SMS_TRANS_W-1:0] trans_len;    // length for that transition
    logic trans_done;                     // transition finished
    logic trans_abort;                    // target changed mid-way
    wire in_trans = (state_r == SMS_TO_MOTION) || (state_r == SMS_TO_STANDSTILL)
        || (state_r == SMS_TO_ESTOP);

    // next-state selection
    always_comb begin
        state_nxt = state_r;
        act_idx_nxt = act_idx_r;
        tgt_idx_nxt = tgt_idx_r;
        trans_start = 1'b0;
        trans_abort = 1'b0;
        trans_len = DECEL_TRANS_CYC;
        case (state_r)
            SMS_ESTOP: begin
                // standstill entered directly from estop
                if (!estop_r && stand_req) begin
                    state_nxt = SMS_STANDSTILL;
                end else if (!estop_r && !ms_r) begin
                    state_nxt = SMS_NORMAL;
                end
            end
            SMS_TO_ESTOP: begin
                // old supervision stays until stop ends
                if (trans_done) begin
                    state_nxt = SMS_ESTOP;
                end
            end
            default: begin
                if (estop_r) begin
                    // emergency stop overrides everything
                    state_nxt = SMS_TO_ESTOP;
                    trans_abort = in_trans;
                    trans_start = 1'b1;
                    trans_len = STOP_TRANS_CYC;
                end else if (motion_req && !((state_r == SMS_MOTION
                        || state_r == SMS_TO_MOTION) && tgt_idx_r == req_idx)) begin
                    // new variant: decelerate first
                    state_nxt = SMS_TO_MOTION;
                    tgt_idx_nxt = req_idx;
                    trans_abort = in_trans;
                    trans_start = 1'b1;
                end else if (state_r == SMS_TO_MOTION && trans_done) begin
                    state_nxt = SMS_MOTION;
                    act_idx_nxt = tgt_idx_r;
                end else if (state_r == SMS_TO_STANDSTILL && trans_done) begin
                    state_nxt = SMS_STANDSTILL;
                end else if (stand_req && state_r != SMS_STANDSTILL
                        && state_r != SMS_TO_STANDSTILL) begin
                    // category one or two stop into standstill
                    state_nxt = SMS_TO_STANDSTILL;
                    trans_abort = in_trans;
                    trans_start = 1'b1;
                    trans_len = STOP_TRANS_CYC;
                end else if (!ms_r && !motion_req) begin
                    state_nxt = SMS_NORMAL;
                    trans_abort = in_trans;
                end
            end
        endcase
    end

    // state update
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state_r <= SMS_NORMAL;
            act_idx_r <= '0;
            tgt_idx_r <= '0;
        end else begin
            state_r <= state_nxt;
            act_idx_r <= act_idx_nxt;
            tgt_idx_r <= tgt_idx_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transition and activation timers
    sms_trans_timer u_trans (
        .clk(CLOCK),
        .rst(RESET),
        .start(trans_start),
        .abort(trans_abort),
        .len(trans_len),
        .done(trans_done)
    );

    wire act_ovr;   // activation overrun from timer
    // limit of the variant being selected
    wire [SMS_LIMIT_W-1:0] act_limit = VARIANT_CFG[req_idx].max_act;

    sms_act_timer #(
        .TICK_CYC(TICK_CYC)
    ) u_act (
        .clk(CLOCK),
        .rst(RESET),
        .run(timer_run),
        .limit(act_limit),
        .overrun(act_ovr)
    );

    ////////////////////////////////////////////////////////////////////
    // reported state: the state whose supervision is in force
    sms_state_t shown_r;                 // last settled state
    // settled state only moves when not in transition
    wire sms_state_t shown_nxt = in_trans ? shown_r : state_r;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            shown_r <= SMS_NORMAL;
        end else begin
            shown_r <= shown_nxt;
        end
    end

    // diagnostic from the settled state
    wire [4:0] diag_nxt = (shown_nxt == SMS_MOTION)
        ? SMS_DIAG_BASE + 5'(act_idx_nxt)
        : (shown_nxt == SMS_STANDSTILL) ? SMS_DIAG_STANDSTILL
        : (shown_nxt == SMS_ESTOP) ? SMS_DIAG_ESTOP : SMS_DIAG_NONE;

    // supervision set of the settled state
    sms_sup_t sup_nxt;
    always_comb begin
        sup_nxt = '0;
        if (shown_nxt == SMS_MOTION) begin
            sup_nxt.speed_limit_supervision = 1'b1;
            sup_nxt.transient_oscillation_check =
                VARIANT_CFG[act_idx_nxt].transient_oscillation_check;
            sup_nxt.direction_check = VARIANT_CFG[act_idx_nxt].direction_check;
            sup_nxt.increment_check = VARIANT_CFG[act_idx_nxt].increment_check;
            sup_nxt.monitored_position_check =
                VARIANT_CFG[act_idx_nxt].monitored_position_check;
            sup_nxt.limited_position_check =
                VARIANT_CFG[act_idx_nxt].limited_position_check;
        end else if (shown_nxt == SMS_STANDSTILL) begin
            sup_nxt.standstill = 1'b1;
        end else if (shown_nxt == SMS_ESTOP) begin
            sup_nxt.emergency_stop = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            VARIANT_ACTIVE_DIAGNOSTIC <= SMS_DIAG_NONE;
            MOTION_REQUEST_PRESENT <= 1'b0;
            MOTION_MODE_ACTIVE <= 1'b0;
            TRANSITION_IN_PROGRESS <= 1'b0;
            ACTIVATION_OVERRUN_ERROR <= 1'b0;
            SUPERVISION <= '0;
        end else begin
            VARIANT_ACTIVE_DIAGNOSTIC <= diag_nxt;
            MOTION_REQUEST_PRESENT <= full_sel;
            MOTION_MODE_ACTIVE <= (shown_nxt == SMS_MOTION);
            TRANSITION_IN_PROGRESS <= (state_nxt == SMS_TO_MOTION)
                || (state_nxt == SMS_TO_STANDSTILL)
                || (state_nxt == SMS_TO_ESTOP);
            ACTIVATION_OVERRUN_ERROR <= act_ovr;
            SUPERVISION <= sup_nxt;
        end
    end
endmodule

/* File: hw/sms_pkg.sv */
/*
 * sms_pkg: constants and types for the reduced-motion-mode selector.
 * assumes: one 200 MHz clock, synchronous active-high reset.
 */
package sms_pkg;
    // number of motion-mode variants
    localparam int SMS_NUM_VARIANTS = 16;
    // width of variant index
    localparam int SMS_IDX_W = 4;
    // width of activation limit in ticks
    localparam int SMS_LIMIT_W = 16;
    // width of transition time count
    localparam int SMS_TRANS_W = 16;
    // clock rate in MHz
    localparam int SMS_CLK_MHZ = 200;
    // activation timer tick, microseconds
    localparam int SMS_TICK_US = 1000;
    // cycles per tick, derived from rate
    localparam int SMS_TICK_CYC = SMS_TICK_US * SMS_CLK_MHZ;
    // width of tick prescaler
    localparam int SMS_PRE_W = 18;
    // limit value meaning supervision off
    localparam logic [SMS_LIMIT_W-1:0] SMS_LIMIT_OFF = 16'h0000;
    // diagnostic code for normal operation (none active)
    localparam logic [4:0] SMS_DIAG_NONE = 5'h00;
    // diagnostic code offset: variant index 0 reports 1
    localparam logic [4:0] SMS_DIAG_BASE = 5'h01;
    // diagnostic code for standstill mode
    localparam logic [4:0] SMS_DIAG_STANDSTILL = 5'h11;
    // diagnostic code for emergency-stop mode
    localparam logic [4:0] SMS_DIAG_ESTOP = 5'h12;

    // per-variant configuration
    typedef struct packed {
        logic selectable;                 // variant may be chosen
        logic transient_oscillation_check;
        logic direction_check;
        logic increment_check;
        logic monitored_position_check;
        logic limited_position_check;
        logic [SMS_LIMIT_W-1:0] max_act;  // activation limit in ticks
    } sms_cfg_t;

    // supervision enables driven toward the monitors
    typedef struct packed {
        logic speed_limit_supervision;
        logic transient_oscillation_check;
        logic direction_check;
        logic increment_check;
        logic monitored_position_check;
        logic limited_position_check;
        logic standstill;
        logic emergency_stop;
    } sms_sup_t;

    // operating states
    typedef enum logic [2:0] {
        SMS_NORMAL,
        SMS_TO_MOTION,
        SMS_MOTION,
        SMS_TO_STANDSTILL,
        SMS_STANDSTILL,
        SMS_TO_ESTOP,
        SMS_ESTOP
    } sms_state_t;
endpackage

/* File: hw/sms_act_timer.sv */
/*
 * sms_act_timer: enabling-control activation timer with overrun flag.
 * assumes: run is a level from the selector; limit follows the requested variant, may change while running.
 */
`timescale 1ns/10ps
module sms_act_timer
    import sms_pkg::*;
#(
    parameter int TICK_CYC = SMS_TICK_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [SMS_LIMIT_W-1:0] limit,
    // status
    output logic overrun
);
    logic [SMS_PRE_W-1:0] pre_r;          // cycle prescaler
    logic [SMS_LIMIT_W-1:0] cnt_r;        // elapsed ticks
    logic ovr_r;                          // sticky while running
    wire tick = (pre_r == SMS_PRE_W'(TICK_CYC - 1));
    wire sat = (cnt_r == {SMS_LIMIT_W{1'b1}});
    wire over = (limit != SMS_LIMIT_OFF) && (cnt_r >= limit);

    ////////////////////////////////////////////////////////////////////
    // prescaler: fixed ticks from the clock
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            pre_r <= '0;
        end else begin
            pre_r <= tick ? '0 : pre_r + 1'b1;
        end
    end

    // tick counter, cleared on reset or when run drops
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            cnt_r <= '0;
        end else if (tick && !sat) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // overrun flag holds until the full selection (selector, enabling, variant) drops
    always_ff @(posedge clk) begin
        if (rst || !run) begin
            ovr_r <= 1'b0;
        end else if (over) begin
            ovr_r <= 1'b1;
        end
    end

    assign overrun = ovr_r;
endmodule

/* File: hw/sms_trans_timer.sv */
/*
 * sms_trans_timer: one-shot transition duration counter.
 * assumes: start is a one-cycle pulse; done pulses once when time ends.
 */
`timescale 1ns/10ps
module sms_trans_timer
    import sms_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [SMS_TRANS_W-1:0] len,
    // status
    output logic done
);
    logic [SMS_TRANS_W-1:0] cnt_r;   // remaining cycles
    logic busy_r;                    // counting
    logic done_r;                    // completion pulse

    ////////////////////////////////////////////////////////////////////
    // countdown; zero length still takes one cycle
    // a restart beats an abort so a retargeted transition still ends
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start) begin
            cnt_r <= len;
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (abort) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (busy_r && cnt_r == '0) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
        end else begin
            cnt_r <= busy_r ? cnt_r - 1'b1 : cnt_r;
            done_r <= 1'b0;
        end
    end

    assign done = done_r;
endmodule

/* File: verif/sms_selector_properties.sv */
/*
 * sms_selector_properties: port-level checks for the mode selector.
 * assumes: bound to sms_selector; one clock, synchronous reset.
 */
`timescale 1ns/10ps
module sms_selector_chk
    import sms_pkg::*;
#(
    parameter int NUM_VARIANTS = SMS_NUM_VARIANTS
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // operator inputs
    input wire logic MODE_SELECTOR_INPUT,
    input wire logic ENABLING_CONTROL_INPUT,
    input wire logic [NUM_VARIANTS-1:0] VARIANT_SELECT_INPUT,
    input wire logic EMERGENCY_STOP_INPUT,
    // status
    input wire logic [4:0] VARIANT_ACTIVE_DIAGNOSTIC,
    input wire logic MOTION_REQUEST_PRESENT,
    input wire logic MOTION_MODE_ACTIVE,
    input wire logic TRANSITION_IN_PROGRESS,
    input wire logic ACTIVATION_OVERRUN_ERROR,
    input wire sms_sup_t SUPERVISION
);
    // full selection at the pins
    logic req;
    assign req = MODE_SELECTOR_INPUT & ENABLING_CONTROL_INPUT & (|VARIANT_SELECT_INPUT);

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////
    property p_estop; $rose(MOTION_MODE_ACTIVE) |-> !$past(EMERGENCY_STOP_INPUT, 3); endproperty
    a_estop: assert property (p_estop) else $error("motion entered with stop");
    property p_full; $rose(MOTION_MODE_ACTIVE) |-> $past(req, 3); endproperty
    a_full: assert property (p_full) else $error("motion without full selection");
    property p_after; $rose(MOTION_MODE_ACTIVE) |-> $past(TRANSITION_IN_PROGRESS, 2); endproperty
    a_after: assert property (p_after) else $error("motion without transition");
    property p_speed; MOTION_MODE_ACTIVE |-> SUPERVISION.speed_limit_supervision; endproperty
    a_speed: assert property (p_speed) else $error("speed limit off in motion");
    property p_diag;
        MOTION_MODE_ACTIVE |-> VARIANT_ACTIVE_DIAGNOSTIC inside {[5'h01:5'h10]};
    endproperty
    a_diag: assert property (p_diag) else $error("bad variant code");
    property p_reset;
        $past(RESET) |-> !MOTION_MODE_ACTIVE && !ACTIVATION_OVERRUN_ERROR
            && VARIANT_ACTIVE_DIAGNOSTIC == SMS_DIAG_NONE;
    endproperty
    a_reset: assert property (p_reset) else $error("not clear after reset");
    property p_req; MOTION_REQUEST_PRESENT == $past(req, 2); endproperty
    a_req: assert property (p_req) else $error("request flag wrong");
    property p_run; $rose(ACTIVATION_OVERRUN_ERROR) |-> $past(req) && $past(req, 2); endproperty
    a_run: assert property (p_run) else $error("overrun without selection");
    property p_keep; (ACTIVATION_OVERRUN_ERROR && req) [*3] |=> ACTIVATION_OVERRUN_ERROR; endproperty
    a_keep: assert property (p_keep) else $error("overrun dropped");
    property p_hold;
        TRANSITION_IN_PROGRESS && $past(TRANSITION_IN_PROGRESS) |-> $stable(VARIANT_ACTIVE_DIAGNOSTIC);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved in transition");
    // main scenarios
    c_enter: cover property ($rose(MOTION_MODE_ACTIVE));
    c_over: cover property ($rose(ACTIVATION_OVERRUN_ERROR));
    c_still: cover property (VARIANT_ACTIVE_DIAGNOSTIC == SMS_DIAG_STANDSTILL);
endmodule

bind sms_selector sms_selector_chk #(.NUM_VARIANTS(NUM_VARIANTS)) u_chk (.*);

/* File: verif/sms_operator.sv */
/*
 * sms_operator: operator panel and supervising controller model.
 * assumes: the bench changes its wants off the rising edge.
 */
`timescale 1ns/10ps
module sms_operator
    import sms_pkg::*;
#(
    parameter bit HOMED = 1'b1
) (
    // bench wants
    input wire logic want_sel,
    input wire logic want_ec,
    input wire logic [4:0] want_var,
    input wire logic want_stop,
    // safety inputs
    output logic ms,
    output logic ec,
    output logic [15:0] sel,
    output logic estop,
    // variant setup
    output sms_cfg_t [15:0] cfg
);
    assign ms = want_sel;
    assign ec = want_ec;
    assign estop = want_stop;
    // one select at most, from an index (0 none)
    assign sel = (want_var == 5'h00) ? 16'h0000 : 16'h0001 << (want_var - 5'h01);
    // position checks only offered once homed; limit 8*i ticks
    for (genvar i = 0; i < 16; i++) begin : g_cfg
        localparam logic [3:0] b = i;
        assign cfg[i] = {i != 15, b[0], b[1], b[2], HOMED & b[3], HOMED & b[0], 16'(8 * i)};
    end
endmodule

/* File: verif/sms_selector_tb.sv */
/*
 * sms_selector_tb: scenario bench for the mode selector.
 * assumes: operator model in front; short tick and transitions.
 */
`timescale 1ns/10ps
module sms_selector_tb;
    import sms_pkg::*;
    logic clk, rst, w_sel, w_ec, w_stop, ms, ec, estop, reqp, active, trans, err;
    logic [4:0] w_var;
    logic [4:0] diag;
    logic [15:0] sel;
    sms_cfg_t [15:0] cfg;
    sms_sup_t sup;
    int errors, comparisons;

    sms_operator op (.want_sel(w_sel), .want_ec(w_ec), .want_var(w_var), .want_stop(w_stop),
        .ms(ms), .ec(ec), .sel(sel), .estop(estop), .cfg(cfg));
    sms_selector #(.TICK_CYC(4)) dut (.CLOCK(clk), .RESET(rst), .MODE_SELECTOR_INPUT(ms),
        .ENABLING_CONTROL_INPUT(ec), .VARIANT_SELECT_INPUT(sel), .EMERGENCY_STOP_INPUT(estop),
        .VARIANT_CFG(cfg), .STANDSTILL_USES_CAT_TWO(1'b0), .DECEL_TRANS_CYC(16'h0003),
        .STOP_TRANS_CYC(16'h0003), .VARIANT_ACTIVE_DIAGNOSTIC(diag),
        .MOTION_REQUEST_PRESENT(reqp), .MOTION_MODE_ACTIVE(active),
        .TRANSITION_IN_PROGRESS(trans), .ACTIVATION_OVERRUN_ERROR(err), .SUPERVISION(sup));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic results;
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // drive the operator wants at the falling edge
    task automatic drive(input logic s, input logic e, input int v, input logic st);
        @(negedge clk);
        w_sel = s;
        w_ec = e;
        w_var = 5'(v);
        w_stop = st;
    endtask

    // bounded wait for a level
    task automatic wait_on(ref logic sig, input logic lvl, input int lim);
        for (int n = 0; sig !== lvl; n++) begin
            if (n == lim) begin
                errors++;
                $display("ERROR wait expected %h seen %h", lvl, sig);
                results;
            end
            @(negedge clk);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // entry into variant i+1 from normal operation
    task automatic t_enter(input int i, input bit rel);
        logic [3:0] b;
        b = 4'(i);
        drive(1, 1, i + 1, 0);
        wait_on(trans, 1'b1, 6);
        check("diag old", 16'(diag), 16'(SMS_DIAG_NONE));
        check("sup old", 16'(sup), 16'h0000);
        wait_on(active, 1'b1, 12);
        check("diag", 16'(diag), 16'(i + 1));
        check("sup", 16'(sup), 16'({1'b1, b[0], b[1], b[2], b[3], b[0], 2'b00}));
        check("req", 16'(reqp), 16'h0001);
        if (rel) begin
            drive(0, 0, 0, 0);
            wait_on(active, 1'b0, 6);
            repeat (4) @(negedge clk);
        end
    endtask

    // zero limit: held long, never overrun
    task automatic t_zero;
        t_enter(0, 0);
        repeat (60) @(negedge clk);
        check("zero limit", 16'(err), 16'h0000);
        drive(0, 0, 0, 0);
        repeat (6) @(negedge clk);
    endtask

    // overrun on variant 2 (32 cycles), then a direct change
    task automatic t_overrun;
        drive(1, 1, 2, 0);
        repeat (28) @(negedge clk);
        check("early", 16'(err), 16'h0000);
        wait_on(err, 1'b1, 10);
        drive(1, 0, 2, 0);
        wait_on(err, 1'b0, 6);
        drive(0, 0, 0, 0);
        repeat (6) @(negedge clk);
        drive(1, 1, 3, 0);
        repeat (28) @(negedge clk);
        check("long limit", 16'(err), 16'h0000);
        drive(1, 1, 2, 0);
        wait_on(err, 1'b1, 8);
        drive(0, 0, 0, 0);
        repeat (8) @(negedge clk);
    endtask

    // enabling dropped in motion: stop transition into standstill
    task automatic t_standstill;
        t_enter(4, 0);
        drive(1, 0, 0, 0);
        wait_on(trans, 1'b1, 6);
        check("stop diag", 16'(diag), 16'h0005);
        check("stop sup", 16'(sup.speed_limit_supervision), 16'h0001);
        wait_on(trans, 1'b0, 12);
        // settled diagnostic follows the transition flag by one cycle
        @(negedge clk);
        check("still diag", 16'(diag), 16'(SMS_DIAG_STANDSTILL));
        check("still act", 16'(active), 16'h0000);
    endtask

    // refusals: unselectable variant, then emergency stop
    task automatic t_refuse;
        drive(1, 1, 16, 0);
        repeat (20) @(negedge clk);
        check("unsel act", 16'(active), 16'h0000);
        check("unsel req", 16'(reqp), 16'h0001);
        drive(1, 1, 1, 1);
        repeat (20) @(negedge clk);
        check("stop act", 16'(active), 16'h0000);
        check("stop diag", 16'(diag), 16'(SMS_DIAG_ESTOP));
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        w_sel = 1'b0;
        w_ec = 1'b0;
        w_var = 5'h00;
        w_stop = 1'b0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        check("rst diag", 16'(diag), 16'h0000);
        check("rst flags", 16'({active, trans, err, reqp}), 16'h0000);
        for (int i = 0; i < 15; i++) begin
            t_enter(i, 1);
        end
        t_zero;
        t_overrun;
        t_standstill;
        t_refuse;
        results;
    end
endmodule
